// *** bst_pkg.sv ***
// Shared constants and types for the boundary-scan test access port.
// Assumes the TAP logic runs on the tester clock and the core side on clk.

package bst_pkg;

  // ---------------------------------------------------------------------
  // Register widths and capture patterns
  // ---------------------------------------------------------------------
  localparam int          BST_IR_W    = 8;
  localparam int          BST_BSR_W   = 135;
  localparam int          BST_ID_W    = 32;
  localparam logic [1:0]  BST_IR_CAPT = 2'h1;
  localparam logic        BST_BYP_CAPT = 1'h0;

  // ---------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------
  localparam logic [134:0] BST_BSR_RST = 135'h0;
  localparam logic [31:0]  BST_ID_RST  = 32'h0000_0000;
  localparam logic [7:0]   BST_IR_RST  = 8'h01;

  // Identification word; the value is arbitrary, LSB set as the convention asks.
  localparam logic [31:0]  BST_ID_CODE = 32'h0A5C_0001;

  // Instruction codes; all other codes act as a bypass.
  localparam logic [7:0] BST_OP_EXTEST = 8'h00;
  localparam logic [7:0] BST_OP_IDCODE = 8'h01;
  localparam logic [7:0] BST_OP_SAMPLE = 8'h02;
  localparam logic [7:0] BST_OP_CLAMP  = 8'h03;
  localparam logic [7:0] BST_OP_HIGHZ  = 8'h04;
  localparam logic [7:0] BST_OP_MR01   = 8'h05;
  localparam logic [7:0] BST_OP_MR2    = 8'h06;
  localparam logic [7:0] BST_OP_BYPASS = 8'hFF;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SHF_DR, BST_EX1_DR,
    BST_PAU_DR, BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR,
    BST_SHF_IR, BST_EX1_IR, BST_PAU_IR, BST_EX2_IR, BST_UPD_IR
  } bst_tap_state_t;

  typedef enum logic [1:0] {BST_PATH_BSR, BST_PATH_ID, BST_PATH_BYP} bst_path_t;

endpackage

// *** bst_sync.sv ***
// Two-flop synchroniser for levels and quasi-static words.
// Assumes each bit is stable long enough to be seen; words are not coherent.
`timescale 1ns/1ps

module bst_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } bst_sync_st_t;

  bst_sync_st_t s_reg;
  bst_sync_st_t s_next;

  // The first stage feeds only the second stage.
  always_comb begin
    s_next.meta   = d;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.stable;

endmodule // bst_sync

// *** bst_tap_fsm.sv ***
// Sixteen-state TAP controller stepped by the mode select line.
// Assumes tms is launched by the tester relative to the test clock.
`timescale 1ns/1ps

module bst_tap_fsm
  import bst_pkg::*;
(
  input  wire logic     tck,
  input  wire logic     rst,
  input  wire logic     tms,
  output bst_tap_state_t state
);

  typedef struct packed {
    bst_tap_state_t state;
  } bst_fsm_st_t;

  bst_fsm_st_t f_reg;
  bst_fsm_st_t f_next;

  // Next state from the sampled select value; five highs reach reset from anywhere.
  always_comb begin
    f_next = f_reg;
    unique case (f_reg.state)
      BST_TLR:    f_next.state = tms ? BST_TLR    : BST_RTI;
      BST_RTI:    f_next.state = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: f_next.state = tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: f_next.state = tms ? BST_EX1_DR : BST_SHF_DR;
      BST_SHF_DR: f_next.state = tms ? BST_EX1_DR : BST_SHF_DR;
      BST_EX1_DR: f_next.state = tms ? BST_UPD_DR : BST_PAU_DR;
      BST_PAU_DR: f_next.state = tms ? BST_EX2_DR : BST_PAU_DR;
      BST_EX2_DR: f_next.state = tms ? BST_UPD_DR : BST_SHF_DR;
      BST_UPD_DR: f_next.state = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: f_next.state = tms ? BST_TLR    : BST_CAP_IR;
      BST_CAP_IR: f_next.state = tms ? BST_EX1_IR : BST_SHF_IR;
      BST_SHF_IR: f_next.state = tms ? BST_EX1_IR : BST_SHF_IR;
      BST_EX1_IR: f_next.state = tms ? BST_UPD_IR : BST_PAU_IR;
      BST_PAU_IR: f_next.state = tms ? BST_EX2_IR : BST_PAU_IR;
      BST_EX2_IR: f_next.state = tms ? BST_UPD_IR : BST_SHF_IR;
      BST_UPD_IR: f_next.state = tms ? BST_SEL_DR : BST_RTI;
    endcase
  end

  // Power-up reset puts the controller in its reset state with no tester action.
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      f_reg.state <= BST_TLR;
    end else begin
      f_reg <= f_next;
    end
  end

  assign state = f_reg.state;

endmodule // bst_tap_fsm

// *** bst_tap_top.sv ***
// Boundary-scan test access port of the memory device.
// Assumes tck comes from the tester and may stop; clk is the core clock.
// Ball values arrive asynchronously; mode words are quasi-static.
`timescale 1ns/1ps

module bst_tap_top
  import bst_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tck,
  input  wire logic         tms,
  input  wire logic         tdi,
  output logic              tdo,
  output logic              tdo_oe,
  input  wire logic [134:0] ball_in,
  input  wire logic [31:0]  mode_reg_one_word,
  input  wire logic [31:0]  mode_reg_two_word,
  output logic      [134:0] bscan_out,
  output logic              bscan_drive_en,
  output logic              outputs_highz
);

  // ---------------------------------------------------------------------
  // Overview
  // ---------------------------------------------------------------------

  // Two clock domains meet here. The test clock runs the controller, the
  // instruction register and all three data registers, and it may stop for
  // long stretches between frames. The core clock runs the core-side crossing flops,
  // the toggle edge flop and the three outputs that steer the memory's pins during boundary test.
  //
  // Nothing in the core domain ever waits for the test clock. A stopped
  // tester therefore leaves the core outputs at their last values, and a
  // reset by mode select reaches the core side only as an instruction change.
  //
  // The serial path is a mux, not a chain of registers: exactly one register
  // is in the path at a time, chosen by the loaded instruction. Shift-IR is
  // the one exception, where the instruction shift stage takes the path
  // whatever instruction is loaded.
  //
  // The instruction shift stage and the loaded instruction are separate, so a
  // half-shifted instruction never reaches the decode. Only Update-IR copies
  // one into the other.

  // ---------------------------------------------------------------------
  // State of the test clock domain
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]   ir_shift;
    logic [7:0]   instruction_reg;
    logic         bypass_bit;
    logic [31:0]  id_shift;
    logic [134:0] boundary_chain;
    logic [134:0] chain_latch;
    logic         latch_toggle;
    logic         drive_lvl;
    logic         highz_lvl;
  } bst_tck_st_t;

  // Serial output stage, launched on the falling test clock edge.
  typedef struct packed {
    logic tdo;
    logic oe;
  } bst_out_st_t;

  // State of the core clock domain.
  typedef struct packed {
    logic         toggle_seen;
    logic [134:0] bscan_out;
    logic         drive_en;
    logic         highz;
  } bst_clk_st_t;

  bst_tck_st_t    t_reg;
  bst_tck_st_t    t_next;
  bst_out_st_t    o_reg;
  bst_out_st_t    o_next;
  bst_clk_st_t    c_reg;
  bst_clk_st_t    c_next;
  bst_tap_state_t tap_state;
  bst_path_t      path;
  logic [134:0]   ball_sync;
  logic [63:0]    mode_sync;
  logic [2:0]     core_sync;

  // ---------------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------------

  // Exactly one register per instruction; unknown codes fall back to bypass.
  function automatic bst_path_t path_of(input logic [7:0] op);
    bst_path_t p;
    p = BST_PATH_BYP;
    if (op == BST_OP_EXTEST || op == BST_OP_SAMPLE) begin
      p = BST_PATH_BSR;
    end else if (op == BST_OP_IDCODE || op == BST_OP_MR01 || op == BST_OP_MR2) begin
      p = BST_PATH_ID;
    end
    return p;
  endfunction

  assign path = path_of(t_reg.instruction_reg);

  // ---------------------------------------------------------------------
  // Controller and synchronisers
  // ---------------------------------------------------------------------

  bst_tap_fsm u_fsm (
    .tck   (tck),
    .rst   (rst),
    .tms   (tms),
    .state (tap_state)
  );

  // Every input from outside the test clock domain passes two flops before
  // any logic reads it; the serial pins are already in that domain.
  // Balls change with the core clock, so they pass two test-clock flops first.
  // A ball in transition during capture may still read either way.
  bst_sync #(.W(135)) u_ball_sync (
    .clk (tck),
    .rst (rst),
    .d   (ball_in),
    .q   (ball_sync)
  );

  // Mode words only change on a mode register write, long before a scan reads them.
  bst_sync #(.W(64)) u_mode_sync (
    .clk (tck),
    .rst (rst),
    .d   ({mode_reg_two_word, mode_reg_one_word}),
    .q   (mode_sync)
  );

  // Update toggle and the two instruction levels cross into the core domain.
  bst_sync #(.W(3)) u_core_sync (
    .clk (clk),
    .rst (rst),
    .d   ({t_reg.latch_toggle, t_reg.drive_lvl, t_reg.highz_lvl}),
    .q   (core_sync)
  );

  // ---------------------------------------------------------------------
  // Test clock domain: instruction and data registers
  // ---------------------------------------------------------------------

  // Every register holds unless its own capture, shift or update state is current; Test-Logic-Reset also loads the instruction.
  // Capture, shift and update all act on the rising edge that leaves the
  // state in question, which is how the transition graph is meant to be read.
  // Unknown instructions use the bypass bit, so the path length is always
  // defined, even for codes that were never given a register of their own.
  always_comb begin
    t_next = t_reg;
    unique case (tap_state)
      BST_TLR: begin
        t_next.instruction_reg = BST_OP_IDCODE;
      end
      BST_CAP_IR: begin
        t_next.ir_shift = {t_reg.ir_shift[7:2], BST_IR_CAPT};
      end
      BST_SHF_IR: begin
        t_next.ir_shift = {tdi, t_reg.ir_shift[7:1]};
      end
      BST_UPD_IR: begin
        t_next.instruction_reg = t_reg.ir_shift;
      end
      BST_CAP_DR: begin
        unique case (path)
          BST_PATH_BSR: begin
            t_next.boundary_chain = ball_sync;
          end
          BST_PATH_ID: begin
            if (t_reg.instruction_reg == BST_OP_MR01) begin
              t_next.id_shift = mode_sync[31:0];
            end else if (t_reg.instruction_reg == BST_OP_MR2) begin
              t_next.id_shift = mode_sync[63:32];
            end else begin
              t_next.id_shift = BST_ID_CODE;
            end
          end
          BST_PATH_BYP: begin
            t_next.bypass_bit = BST_BYP_CAPT;
          end
          default: begin
            t_next.bypass_bit = BST_BYP_CAPT;
          end
        endcase
      end
      BST_SHF_DR: begin
        unique case (path)
          BST_PATH_BSR: begin
            t_next.boundary_chain = {tdi, t_reg.boundary_chain[134:1]};
          end
          BST_PATH_ID: begin
            t_next.id_shift = {tdi, t_reg.id_shift[31:1]};
          end
          BST_PATH_BYP: begin
            t_next.bypass_bit = tdi;
          end
          default: begin
            t_next.bypass_bit = tdi;
          end
        endcase
      end
      BST_UPD_DR: begin
        // Only the chain owns parallel outputs, so only it updates here.
        if (path == BST_PATH_BSR) begin
          t_next.chain_latch  = t_reg.boundary_chain;
          t_next.latch_toggle = ~t_reg.latch_toggle;
        end
      end
      BST_RTI, BST_SEL_DR, BST_EX1_DR, BST_PAU_DR, BST_EX2_DR,
      BST_SEL_IR, BST_EX1_IR, BST_PAU_IR, BST_EX2_IR: begin
        t_next = t_reg;
      end
    endcase
    // Registered levels keep the crossing glitch free.
    t_next.drive_lvl = (t_next.instruction_reg == BST_OP_EXTEST) ||
                       (t_next.instruction_reg == BST_OP_CLAMP);
    t_next.highz_lvl = (t_next.instruction_reg == BST_OP_HIGHZ);
  end

  // Rising test clock edge captures all serial and mode inputs.
  // Power-up leaves the identification code loaded, so the first data scan
  // reads the identification word without any instruction scan before it.
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      t_reg.ir_shift        <= BST_IR_RST;
      t_reg.instruction_reg <= BST_IR_RST;
      t_reg.bypass_bit      <= BST_BYP_CAPT;
      t_reg.id_shift        <= BST_ID_RST;
      t_reg.boundary_chain  <= BST_BSR_RST;
      t_reg.chain_latch     <= BST_BSR_RST;
      t_reg.latch_toggle    <= 1'h0;
      t_reg.drive_lvl       <= 1'h0;
      t_reg.highz_lvl       <= 1'h0;
    end else begin
      t_reg <= t_next;
    end
  end

  // ---------------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------------

  // LSB of the register in the path; the driver works only while shifting.
  // The mux reads the registers as they stand after the last rising edge,
  // so the value launched on the falling edge is the bit that the next
  // rising edge shifts out of the register.
  // In every state but the two shift states the enable is low, and the
  // data bit is then of no interest to the pad.
  always_comb begin
    o_next.oe  = (tap_state == BST_SHF_IR) || (tap_state == BST_SHF_DR);
    o_next.tdo = t_reg.bypass_bit;
    if (tap_state == BST_SHF_IR) begin
      o_next.tdo = t_reg.ir_shift[0];
    end else if (path == BST_PATH_BSR) begin
      o_next.tdo = t_reg.boundary_chain[0];
    end else if (path == BST_PATH_ID) begin
      o_next.tdo = t_reg.id_shift[0];
    end
  end

  // Launching on the falling edge gives the tester half a period of setup.
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      o_reg.tdo <= 1'h0;
      o_reg.oe  <= 1'h0;
    end else begin
      o_reg <= o_next;
    end
  end

  assign tdo    = o_reg.tdo;
  assign tdo_oe = o_reg.oe;

  // ---------------------------------------------------------------------
  // Core clock domain
  // ---------------------------------------------------------------------

  // Latency from the test clock edge that leaves Update-DR to a new word on
  // the core outputs is three core clocks: two for the toggle synchroniser
  // and one for the output register.
  // The word itself is not synchronised; it changes on the same test clock
  // edge as the toggle and stands still while the toggle synchronises, and
  // it cannot move again until another full data scan has passed.
  // A trade-off: the latch costs 135 extra flops, but the core side never
  // sees a half-shifted chain on the memory's pins.
  // The latch word is stable for many test clocks after its toggle flips,
  // so it is safe to copy once the synchronised toggle shows a change.
  // A reset by mode select only ends the test instructions; the core side
  // keeps running, so memory operation is not disturbed.
  always_comb begin
    c_next          = c_reg;
    c_next.drive_en = core_sync[1];
    c_next.highz    = core_sync[0];
    if (core_sync[2] != c_reg.toggle_seen) begin
      c_next.toggle_seen = core_sync[2];
      c_next.bscan_out   = t_reg.chain_latch;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_reg.toggle_seen <= 1'h0;
      c_reg.bscan_out   <= BST_BSR_RST;
      c_reg.drive_en    <= 1'h0;
      c_reg.highz       <= 1'h0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign bscan_out      = c_reg.bscan_out;
  assign bscan_drive_en = c_reg.drive_en;
  assign outputs_highz  = c_reg.highz;

endmodule // bst_tap_top

// *** bst_tap_top_monitor.sv ***
// Concurrent checks on the test port pins and the core-side outputs.
// Assumes it is bound to bst_tap_top and sees only that module's ports.
`timescale 1ns/1ps

module bst_tap_top_monitor
  import bst_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         tck,
  input wire logic         tms,
  input wire logic         tdo,
  input wire logic         tdo_oe,
  input wire logic [134:0] bscan_out,
  input wire logic         bscan_drive_en,
  input wire logic         outputs_highz
);
  // ---------------------------------------------------------------------
  // Helper logic and checks
  // ---------------------------------------------------------------------
  logic [2:0] tck_seen_reg;
  logic [7:0] quiet_reg;

  // Core cycles since the last test clock rise; core outputs may only move soon after one.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_seen_reg <= 3'h0;
      quiet_reg    <= 8'hFF;
    end else begin
      tck_seen_reg <= {tck_seen_reg[1:0], tck};
      if (tck_seen_reg[1] && !tck_seen_reg[2]) quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hFF) quiet_reg <= quiet_reg + 8'h01;
    end
  end

  // Entry into Shift-IR from the idle state.
  sequence s_ir_entry;
    !tms ##1 tms [*2] ##1 !tms [*2];
  endsequence

  chk_tdo_hold_high: assert property (@(posedge clk) disable iff (rst)
    (tck && $past(tck)) |-> $stable(tdo) && $stable(tdo_oe)) else $error("tdo moved, tck high");
  chk_oe_enter_low: assert property (@(posedge tck) disable iff (rst)
    $rose(tdo_oe) |-> !$past(tms)) else $error("tdo enabled without shift entry");
  chk_oe_leave_high: assert property (@(posedge tck) disable iff (rst)
    $fell(tdo_oe) |-> $past(tms)) else $error("tdo released without shift exit");
  chk_five_high_tlr: assert property (@(posedge tck) disable iff (rst)
    tms [*5] |=> !tdo_oe) else $error("tdo enabled after five high selects");
  chk_ir_capture_bits: assert property (@(posedge tck) disable iff (rst)
    s_ir_entry ##1 tdo_oe |-> tdo ##1 (!tdo_oe || !tdo)) else $error("capture pattern not 01");
  chk_core_one_mode: assert property (@(posedge clk) disable iff (rst)
    !(bscan_drive_en && outputs_highz)) else $error("drive and highz together");
  chk_latch_quiet: assert property (@(posedge clk) disable iff (rst)
    $changed(bscan_out) |-> quiet_reg < 8'h0C) else $error("latch moved without tck");
  chk_mode_quiet: assert property (@(posedge clk) disable iff (rst)
    $changed({bscan_drive_en, outputs_highz}) |-> quiet_reg < 8'h0C) else $error("mode moved");
  chk_reset_idle: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> !tdo_oe && !bscan_drive_en && !outputs_highz) else $error("not idle");
endmodule // bst_tap_top_monitor

bind bst_tap_top bst_tap_top_monitor i_bst_tap_top_monitor (
  .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe),
  .bscan_out(bscan_out), .bscan_drive_en(bscan_drive_en), .outputs_highz(outputs_highz)
);

// *** bst_jtag_tester.sv ***
// Behavioural boundary-scan tester that clocks frames into the port.
// Assumes the bench calls its tasks; the test clock stands low between frames.
`timescale 1ns/1ps

module bst_jtag_tester (
  output logic        tck,
  output logic        tms,
  output logic        tdi,
  input  wire logic   tdo,
  input  wire logic   tdo_oe,
  output int          oe_bad
);
  // Idle lines rest at their pull-up level.
  initial begin
    tck    = 1'h0;
    tms    = 1'h1;
    tdi    = 1'h1;
    oe_bad = 0;
  end

  // One test clock of 48 ns; tdo is taken just before the rise, from the last fall.
  task automatic step(input logic m, input logic d, input logic oe, output logic o);
    tms = m;
    tdi = d;
    #24;
    // A released pin has no pull here, so it reads as the inverse of the flop.
    o = tdo_oe ? tdo : ~tdo;
    if (tdo_oe !== oe) oe_bad++;
    tck = 1'h1;
    #24;
    tck = 1'h0;
  endtask

  // Five high selects then one low, leaving the port idle.
  task automatic reset5();
    logic o;
    repeat (5) step(1'h1, 1'h1, 1'h0, o);
    step(1'h0, 1'h1, 1'h0, o);
  endtask

  // A whole scan from idle; pz is the bit after which the scan pauses, or -1.
  task automatic scan(input logic ir, input int n, input int pz, input logic [134:0] din,
                      output logic [134:0] dout);
    logic o;
    dout = 135'h0;
    step(1'h1, 1'h1, 1'h0, o);
    if (ir) step(1'h1, 1'h1, 1'h0, o);
    step(1'h0, 1'h1, 1'h0, o);
    step(1'h0, 1'h1, 1'h0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pz, din[i], 1'h1, o);
      dout[i] = o;
      if (i == pz && i != n - 1) begin
        step(1'h0, 1'h1, 1'h0, o);
        step(1'h0, 1'h1, 1'h0, o);
        step(1'h1, 1'h1, 1'h0, o);
        step(1'h0, 1'h1, 1'h0, o);
      end
    end
    step(1'h1, 1'h1, 1'h0, o);
    repeat (3) step(1'h0, 1'h1, 1'h0, o);
    tms = 1'h1;
    tdi = 1'h1;
  endtask
endmodule // bst_jtag_tester

// *** tb_boundary_scan_tap.sv ***
// Self-checking bench for the boundary-scan port with a reference model.
// Assumes bst_pkg, the design, the tester model and the bound checker.
`timescale 1ns/1ps

`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb_boundary_scan_tap
  import bst_pkg::*;
;
  logic         clk, rst, tck, tms, tdi, tdo, tdo_oe, bit_o;
  logic         bscan_drive_en, outputs_highz;
  logic [134:0] ball_in, bscan_out, din, dout, latch;
  logic [31:0]  mode_reg_one_word, mode_reg_two_word;
  int           fail_count, n_checks, oe_bad, seed;

  bst_tap_top i_bst_tap_top (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .ball_in(ball_in), .mode_reg_one_word(mode_reg_one_word),
    .mode_reg_two_word(mode_reg_two_word), .bscan_out(bscan_out),
    .bscan_drive_en(bscan_drive_en), .outputs_highz(outputs_highz));
  bst_jtag_tester i_bst_jtag_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .oe_bad(oe_bad));

  // Core clock, 5 ns.
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [134:0] rnd();
    return 135'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
  endfunction

  // Reference: a queue plays the serial path, the captured register first,
  // then the bits shifted in behind it; n bits come out of the far end.
  function automatic logic [134:0] model_out(logic [7:0] op, logic [134:0] d, int n);
    logic [134:0] cap;
    logic [134:0] r;
    int           cw;
    logic         q[$];
    cap = 135'h0;
    r = 135'h0;
    cw = BST_ID_W;
    case (op)
      BST_OP_EXTEST, BST_OP_SAMPLE: begin
        cap = ball_in;
        cw = BST_BSR_W;
      end
      BST_OP_IDCODE: begin
        cap = 135'(BST_ID_CODE);
      end
      BST_OP_MR01: begin
        cap = 135'(mode_reg_one_word);
      end
      BST_OP_MR2: begin
        cap = 135'(mode_reg_two_word);
      end
      default: begin
        cap = 135'(BST_BYP_CAPT);
        cw = 1;
      end
    endcase
    for (int i = 0; i < cw; i++) begin
      q.push_back(cap[i]);
    end
    for (int i = 0; i < n; i++) begin
      q.push_back(d[i]);
    end
    for (int i = 0; i < n; i++) begin
      r[i] = q.pop_front();
    end
    return r;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Core-side levels, settled well past the crossing lag.
  task automatic core_chk(input logic en, input logic hz);
    repeat (12) @(posedge clk);
    #1;
    `CHK("drive_en", en, bscan_drive_en)
    `CHK("highz", hz, outputs_highz)
    `CHK("bscan_out", latch, bscan_out)
    `CHK("tdo_oe", 1'h0, tdo_oe)
    `CHK("oe_bad", 0, oe_bad)
  endtask

  // Load an instruction, then run one data scan of n bits through its register.
  task automatic do_op(input logic [7:0] op, input int n, input int pz, input logic en,
                       input logic hz);
    logic [134:0] m;
    m = {135{1'h1}} >> (135 - n);
    @(posedge clk);
    #1;
    ball_in = rnd();
    din = rnd();
    i_bst_jtag_tester.scan(1'h1, 8, -1, 135'(op), dout);
    `CHK("ir capture", BST_IR_CAPT, dout[1:0])
    core_chk(en, hz);
    i_bst_jtag_tester.scan(1'h0, n, pz, din, dout);
    `CHK("dr out", model_out(op, din, n) & m, dout)
    if (op == BST_OP_EXTEST || op == BST_OP_SAMPLE) latch = din;
    core_chk(en, hz);
    $display("test op %h done", op);
  endtask

  // Watchdog, several times the expected run length.
  initial begin
    #300000;
    fail_count++;
    complete_run();
  end

  initial begin
    seed = 61;
    fail_count = 0;
    n_checks = 0;
    latch = 135'h0;
    rst = 1'h1;
    ball_in = 135'h0;
    mode_reg_one_word = $random(seed);
    mode_reg_two_word = $random(seed);
    mode_reg_one_word[7] = 1'h0;
    din = rnd();
    fork
      i_bst_jtag_tester.step(1'h1, 1'h1, 1'h0, bit_o);
    join_none
    repeat (16) @(posedge clk);
    #1;
    rst = 1'h0;
    core_chk(1'h0, 1'h0);
    i_bst_jtag_tester.reset5();
    i_bst_jtag_tester.scan(1'h0, 32, -1, din, dout);
    `CHK("id", BST_ID_CODE, dout[31:0])
    $display("test power-up done");
    do_op(BST_OP_SAMPLE, 135, 60, 1'h0, 1'h0);
    do_op(BST_OP_EXTEST, 135, -1, 1'h1, 1'h0);
    do_op(BST_OP_MR01, 32, 5, 1'h0, 1'h0);
    do_op(BST_OP_MR2, 32, -1, 1'h0, 1'h0);
    do_op(BST_OP_CLAMP, 8, -1, 1'h1, 1'h0);
    do_op(BST_OP_BYPASS, 8, 3, 1'h0, 1'h0);
    do_op(8'h5A, 8, -1, 1'h0, 1'h0);
    do_op(BST_OP_HIGHZ, 1, -1, 1'h0, 1'h1);
    i_bst_jtag_tester.reset5();
    core_chk(1'h0, 1'h0);
    i_bst_jtag_tester.scan(1'h0, 32, -1, din, dout);
    `CHK("id after reset", BST_ID_CODE, dout[31:0])
    $display("test select reset done");
    complete_run();
  end
endmodule // tb_boundary_scan_tap
